/* File: hw/bsg_pkg.sv */
/*
  Shared constants, register map and state types of the buzzer sound generator.
  Assumes a 10 MHz reference clock that runs at twice the tone oscillator rate.
*/
package bsg_pkg;
  // Clock and time base; the 256 Hz tick paces the burst and the envelope.
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_PERIOD_NS = 3906250;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int ENV_STEP_SHORT_US = 62500;
  localparam int ENV_STEP_LONG_US = 125000;
  localparam int BURST_SHORT_US = 31250;
  localparam int BURST_LONG_US = 125000;
  localparam logic [5:0] ENV_STEP_SHORT_TICKS = 6'(ENV_STEP_SHORT_US * 1000 / TICK_PERIOD_NS);
  localparam logic [5:0] ENV_STEP_LONG_TICKS = 6'(ENV_STEP_LONG_US * 1000 / TICK_PERIOD_NS);
  localparam logic [5:0] BURST_SHORT_TICKS = 6'(BURST_SHORT_US * 1000 / TICK_PERIOD_NS);
  localparam logic [5:0] BURST_LONG_TICKS = 6'(BURST_LONG_US * 1000 / TICK_PERIOD_NS);

  // Register offsets.
  localparam logic [7:0] ADDR_FLOAT = 8'hA8;
  localparam logic [7:0] ADDR_FSEL = 8'hAA;
  localparam logic [7:0] ADDR_TONE = 8'hE0;
  localparam logic [7:0] ADDR_SHOT = 8'hE1;
  localparam logic [7:0] ADDR_FREQ = 8'hE2;
  localparam logic [7:0] ADDR_DUTY = 8'hE3;
  localparam logic [7:0] ADDR_PORT = 8'hF0;

  // Field positions.
  localparam int TONE_EN_BIT = 0;
  localparam int ENV_EN_BIT = 1;
  localparam int ENV_RESTART_BIT = 2;
  localparam int ENV_TIME_BIT = 3;
  localparam int BURST_WIDTH_BIT = 0;
  localparam int BURST_TRIG_BIT = 1;
  localparam int BURST_STOP_BIT = 2;
  localparam int TRUE_PIN = 3;
  localparam int INV_PIN = 2;

  // Tone shaping.
  localparam logic [2:0] LVL_MIN = 3'h7;
  localparam logic [4:0] PERIOD_BASE = 5'h10;
  localparam logic [4:0] HIGH_SHORT = 5'h9;
  localparam logic [4:0] HIGH_LONG = 5'hD;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } bsg_pins_t;

  typedef struct packed {
    logic [3:0] flt;
    logic [1:0] sel;
    logic tone_en;
    logic env_en;
    logic env_time;
    logic width;
    logic [2:0] div;
    logic [2:0] duty;
    logic [3:0] port;
    logic pend;
    logic busy;
    logic [5:0] burst_cnt;
    logic [5:0] env_cnt;
    logic [2:0] env_lvl;
    logic [15:0] tick_cnt;
    logic tick;
    logic [3:0] rdata;
    bsg_pins_t pins;
  } bsg_state_t;

  typedef struct packed {
    logic [4:0] cnt;
    logic pre;
    logic out;
  } bsg_tone_state_t;

  localparam bsg_state_t STATE_RST = '0;
  localparam bsg_tone_state_t TONE_RST = '0;

  // Period of one tone cycle in units.
  function automatic logic [4:0] tone_period(input logic [2:0] div);
    tone_period = PERIOD_BASE + {1'b0, div[1:0], 2'b00};
  endfunction : tone_period

  // High time in units for a divide code and a level code.
  function automatic logic [4:0] tone_high(input logic [2:0] div, input logic [2:0] lvl);
    tone_high = (div[1] ? HIGH_LONG : HIGH_SHORT) - 5'h1 - {2'b00, lvl};
  endfunction : tone_high
endpackage : bsg_pkg

/* File: hw/bsg_tone_gen.sv */
/*
  Square tone generator: divides the reference clock and shapes the duty.
  Assumes divide and level codes change only between tones; a change mid-tone glitches.
*/
module bsg_tone_gen import bsg_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic run_i,
  input wire logic [2:0] div_i,
  input wire logic [2:0] lvl_i,
  output logic tone_o
);
  bsg_tone_state_t r;
  bsg_tone_state_t s;
  logic adv;

  // Upper divide codes use two clocks per unit, hence the prescaler.
  always_comb begin
    s = r;
    adv = !div_i[2] || r.pre;
    s.pre = div_i[2] ? ~r.pre : 1'b0;
    if (!run_i) begin
      s = TONE_RST;
    end else if (adv) begin
      // (RQ6) period from divide code
      s.cnt = (r.cnt == tone_period(div_i) - 5'h1) ? 5'h0 : r.cnt + 5'h1;
    end
    // (RQ22) high first, then low
    // (RQ7) level sets high units
    s.out = run_i && (s.cnt < tone_high(div_i, lvl_i));
  end

  // One register stage holds all state.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= TONE_RST;
    end else begin
      r <= s;
    end
  end

  assign tone_o = r.out;
endmodule : bsg_tone_gen

/* File: hw/bsg_top.sv */
/*
  Buzzer sound generator: registers, one-shot burst, envelope and pin muxing.
  Assumes a synchronous register master and an external memory mode level input.
*/
// Operation
// (RQ1) Select bits route true/inverted tone to pins.
// (RQ2) Port data stays storage while pin carries tone.
// (RQ3) Float bits release tone pins.
// (RQ4) Low float bits are storage in memory mode.
// (RQ5) Tone enable drives tone, else pins low.
// (RQ6) Divide code picks ratio 8 to 28.
// (RQ7) Duty level sets high time units.
// (RQ8) Envelope replaces duty field while enabled.
// (RQ9) Envelope restart returns level one when running.
// (RQ10) Envelope enable cleared by trigger write.
// (RQ11) Envelope steps every 62.5 or 125 ms.
// (RQ12) Step time ignored while envelope off.
// (RQ13) Burst width 31.25 or 125 ms.
// (RQ14) Trigger starts burst, ends by itself.
// (RQ15) Trigger ignored while tone or burst on.
// (RQ16) Trigger location reads burst busy.
// (RQ17) Force stop ends active burst.
// (RQ18) Stop wins over trigger in one write.
// (RQ19) Software expects glitches on enable/divide changes.
// (RQ20) Burst edges on 256 Hz tick; stop immediate.
// (RQ21) Envelope holds level eight until off/restart.
// (RQ22) High phase first, then low.
module bsg_top import bsg_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [3:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic ext_memory_mode_i,
  output logic [3:0] rdata_o,
  output bsg_pins_t pins_o
);
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  bsg_state_t r;
  bsg_state_t s;
  logic tone_w;
  logic run;
  logic [2:0] lvl;
  logic wr_tone;
  logic wr_shot;
  logic restart;
  logic trig;
  logic stop;
  logic [5:0] step_ticks;
  logic [5:0] width_ticks;

  // The tone runs for the continuous enable or for a burst in progress.
  assign run = r.tone_en || r.busy;
  // (RQ8) envelope overrides duty field
  assign lvl = r.env_en ? r.env_lvl : r.duty;
  assign wr_tone = wr_i && (addr_i == ADDR_TONE);
  assign wr_shot = wr_i && (addr_i == ADDR_SHOT);
  assign restart = wr_tone && wdata_i[ENV_RESTART_BIT];
  assign trig = wr_shot && wdata_i[BURST_TRIG_BIT];
  assign stop = wr_shot && wdata_i[BURST_STOP_BIT];
  // (RQ11) envelope step time
  assign step_ticks = r.env_time ? ENV_STEP_LONG_TICKS : ENV_STEP_SHORT_TICKS;
  // (RQ13) burst width select
  assign width_ticks = r.width ? BURST_LONG_TICKS : BURST_SHORT_TICKS;

  bsg_tone_gen u_tone (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .run_i(run),
    .div_i(r.div),
    .lvl_i(lvl),
    .tone_o(tone_w)
  );

  // Next state of the whole block.
  always_comb begin
    s = r;
    s.rdata = 4'h0;
    // Free running time base; the count is a parameter so benches can shorten it.
    if (r.tick_cnt == TICK_LAST) begin
      s.tick_cnt = 16'h0;
      s.tick = 1'b1;
    end else begin
      s.tick_cnt = r.tick_cnt + 16'h1;
      s.tick = 1'b0;
    end

    // Register writes.
    if (wr_i) begin
      case (addr_i)
        ADDR_FLOAT: s.flt = wdata_i;
        ADDR_FSEL: s.sel = wdata_i[TRUE_PIN:INV_PIN];
        ADDR_TONE: begin
          s.env_time = wdata_i[ENV_TIME_BIT];
          s.env_en = wdata_i[ENV_EN_BIT];
          s.tone_en = wdata_i[TONE_EN_BIT];
        end
        ADDR_SHOT: s.width = wdata_i[BURST_WIDTH_BIT];
        ADDR_FREQ: s.div = wdata_i[2:0];
        ADDR_DUTY: s.duty = wdata_i[2:0];
        // (RQ2) port data kept as storage
        ADDR_PORT: s.port = wdata_i;
        default: s.flt = r.flt;
      endcase
    end

    // (RQ20) burst starts on a tick
    if (r.pend && r.tick) begin
      s.pend = 1'b0;
      s.busy = 1'b1;
      s.burst_cnt = 6'h0;
    end
    // (RQ14) burst ends on its own
    if (r.busy && r.tick) begin
      s.burst_cnt = r.burst_cnt + 6'h1;
      if (r.burst_cnt + 6'h1 >= width_ticks) begin
        s.busy = 1'b0;
      end
    end
    // (RQ10) trigger write drops envelope
    if (trig) begin
      s.env_en = 1'b0;
    end
    // (RQ15) trigger only when idle
    if (trig && !r.tone_en && !r.pend && !r.busy) begin
      s.pend = 1'b1;
    end
    // (RQ17) forced stop, no tick wait
    // (RQ18) stop applied last, so wins
    // An idle stop only clears bits that are already clear, but it must also
    // cancel a trigger carried by the same write.
    if (stop) begin
      s.pend = 1'b0;
      s.busy = 1'b0;
    end

    // Envelope walks from level one down to level eight while the tone runs.
    if (!run || !r.env_en) begin
      // (RQ12) step time unused when off
      s.env_lvl = 3'h0;
      s.env_cnt = 6'h0;
    end else if (restart) begin
      // (RQ9) restart to level one
      s.env_lvl = 3'h0;
      s.env_cnt = 6'h0;
    end else if (r.tick) begin
      // (RQ11) one level per step
      if (r.env_cnt + 6'h1 >= step_ticks) begin
        s.env_cnt = 6'h0;
        // (RQ21) saturate at level eight
        if (r.env_lvl != LVL_MIN) begin
          s.env_lvl = r.env_lvl + 3'h1;
        end
      end else begin
        s.env_cnt = r.env_cnt + 6'h1;
      end
    end

    // Register reads; write-only bits read as zero.
    if (rd_i) begin
      case (addr_i)
        ADDR_FLOAT: s.rdata = r.flt;
        ADDR_FSEL: s.rdata = {r.sel, 2'b00};
        ADDR_TONE: s.rdata = {r.env_time, 1'b0, r.env_en, r.tone_en};
        // (RQ16) busy status readback
        ADDR_SHOT: s.rdata = {2'b00, r.pend || r.busy, r.width};
        ADDR_FREQ: s.rdata = {1'b0, r.div};
        ADDR_DUTY: s.rdata = {1'b0, r.duty};
        ADDR_PORT: s.rdata = r.port;
        default: s.rdata = 4'h0;
      endcase
    end

    // (RQ1) pin function select
    // (RQ5) pins low when tone stopped
    s.pins.out[TRUE_PIN] = r.sel[1] ? (run && tone_w) : r.port[TRUE_PIN];
    s.pins.out[INV_PIN] = r.sel[0] ? (run && !tone_w) : r.port[INV_PIN];
    s.pins.out[1:0] = r.port[1:0];
    // (RQ3) float control on tone pins
    s.pins.oe[TRUE_PIN] = !r.flt[TRUE_PIN];
    s.pins.oe[INV_PIN] = !r.flt[INV_PIN];
    // (RQ4) low float bits idle in memory mode
    s.pins.oe[1:0] = ext_memory_mode_i ? 2'b11 : ~r.flt[1:0];
  end

  // One register stage holds all state; reset takes constants only.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= STATE_RST;
    end else begin
      r <= s;
    end
  end

  assign rdata_o = r.rdata;
  assign pins_o = r.pins;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  burst_start_a: assert property (r.pend && r.tick && !stop |=> r.busy && !r.pend) // (RQ20)
    else $error("burst did not start on tick");
  stop_wins_a: assert property (wr_shot && wdata_i[2:1] == 2'b11 |=> !r.pend && !r.busy) // (RQ18)
    else $error("stop lost to trigger");
  trig_blocked_a: assert property (trig && r.tone_en && !r.pend && !r.busy |=> !r.pend) // (RQ15)
    else $error("trigger taken while tone enabled");
  env_clear_a: assert property (trig |=> !r.env_en) // (RQ10)
    else $error("envelope not cleared by trigger");
  inv_low_a: assert property ((r.sel[0] && !run) [*3] |-> !pins_o.out[INV_PIN]) // (RQ5)
    else $error("inverted pin not low while stopped");
  float_pin_a: assert property (wr_i && addr_i == ADDR_FLOAT && wdata_i[TRUE_PIN] // (RQ3)
    |-> ##2 !pins_o.oe[TRUE_PIN])
    else $error("true pin not floated");
  ext_mode_a: assert property (ext_memory_mode_i |=> pins_o.oe[1:0] == 2'b11) // (RQ4)
    else $error("low pins floated in memory mode");
  env_hold_a: assert property (r.env_lvl == LVL_MIN && run && r.env_en && !restart // (RQ21)
    && !trig && !wr_tone |=> r.env_lvl == LVL_MIN)
    else $error("envelope left level eight");
  stop_read_a: assert property (rd_i && addr_i == ADDR_SHOT |=> rdata_o[3:2] == 2'b00) // (RQ17)
    else $error("stop bit read nonzero");
  status_read_a: assert property (rd_i && addr_i == ADDR_SHOT // (RQ16)
    |=> rdata_o[1] == $past(r.pend || r.busy))
    else $error("busy status wrong");

  burst_run_c: cover property (r.busy ##1 !r.busy);
  env_step_c: cover property (r.env_en && run && r.env_lvl == LVL_MIN);
  forced_stop_c: cover property (stop && r.busy);
endmodule : bsg_top

/* File: sim/bsg_piezo_model.sv */
/*
  Piezo buzzer model hung on the two tone pins; it measures the true pin waveform.
  Assumes the pins are registered on the rising edge of the reference clock.
*/
module bsg_piezo_model import bsg_pkg::*; (
  input wire logic ref_clk_i,
  input wire bsg_pins_t pins_i,
  output logic [15:0] high_len_o,
  output logic [15:0] period_len_o,
  output logic clash_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drive_true;
  logic last;
  logic [15:0] run_cnt;
  logic [15:0] hi_cnt;

  // A released pin moves no membrane, so only a driven high counts.
  assign drive_true = pins_i.oe[3] & pins_i.out[3];

  // Start from a known state; the model has no reset pin.
  initial begin
    {last, run_cnt, hi_cnt, high_len_o, period_len_o, clash_o} = '0;
  end

  // Rising edges give the period, falling edges the high time.
  always_ff @(posedge ref_clk_i) begin
    last <= drive_true;
    run_cnt <= (drive_true & ~last) ? 16'h1 : run_cnt + 16'h1;
    hi_cnt <= drive_true ? hi_cnt + 16'h1 : 16'h0;
    if (drive_true & ~last) begin
      period_len_o <= run_cnt;
    end
    if (~drive_true & last) begin
      high_len_o <= hi_cnt;
    end
    // Both plates driven high together would silence the element.
    clash_o <= clash_o | (&pins_i.oe[3:2] & &pins_i.out[3:2]);
  end
endmodule : bsg_piezo_model

/* File: sim/bsg_top_test.sv */
/*
  Self-checking testbench of the buzzer sound generator top.
  Assumes a short tick parameter so bursts and envelope steps last few hundred clocks.
*/
module bsg_top_test import bsg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 8;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ext_memory_mode_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [3:0] wdata_i = 4'h0;
  logic [3:0] rdata_o;
  logic [3:0] r;
  logic [3:0] f;
  logic [2:0] dv;
  logic [2:0] dt;
  bsg_pins_t pins_o;
  logic [15:0] hi_len;
  logic [15:0] per_len;
  logic clash;
  logic [7:0] ra [7] = '{ADDR_FLOAT, ADDR_FSEL, ADDR_TONE, ADDR_SHOT, ADDR_FREQ, ADDR_DUTY, 8'h55};
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;

  bsg_top #(.TICK_CYCLES(TK)) u_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .ext_memory_mode_i(ext_memory_mode_i), .rdata_o(rdata_o), .pins_o(pins_o));
  bsg_piezo_model u_piezo (.ref_clk_i(ref_clk_i), .pins_i(pins_o), .high_len_o(hi_len),
    .period_len_o(per_len), .clash_o(clash));

  // Reference clock, 100 ns period.
  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic results;
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  task automatic rd(input logic [7:0] a, output logic [3:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    d = rdata_o;
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [3:0] e);
    rd(a, r);
    chk({12'h0, r}, {12'h0, e});
  endtask : rdc

  task automatic waitc(input int k);
    repeat (k) @(posedge ref_clk_i);
  endtask : waitc

  // A tone unit is two clocks for the four slow divide codes.
  function automatic logic [15:0] exp_high(input logic [2:0] d, input logic [2:0] l);
    return 16'(((d[1] ? 13 : 9) - 1 - int'(l)) * (d[2] ? 2 : 1));
  endfunction : exp_high

  function automatic logic [15:0] exp_per(input logic [2:0] d);
    return 16'((16 + 4 * int'(d[1:0])) * (d[2] ? 2 : 1));
  endfunction : exp_per

  // Cut a hang short well beyond the expected run length.
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end

  // Main sequence: reset values, masks, pins, tone shape, envelope and burst.
  initial begin
    void'($urandom(32'h61a982bb));
    repeat (20) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    foreach (ra[i]) rdc(ra[i], 4'h0);
    wr(8'h55, 4'hF);
    rdc(8'h55, 4'h0);
    wr(ADDR_FSEL, 4'hF);
    rdc(ADDR_FSEL, 4'hC);
    wr(ADDR_FREQ, 4'hF);
    rdc(ADDR_FREQ, 4'h7);
    wr(ADDR_DUTY, 4'hF);
    rdc(ADDR_DUTY, 4'h7);
    wr(ADDR_TONE, 4'hC);
    rdc(ADDR_TONE, 4'h8);
    wr(ADDR_TONE, 4'h0);
    for (n = 0; n < 4; n++) begin
      f = 4'($urandom);
      ext_memory_mode_i <= n[0];
      wr(ADDR_FLOAT, f);
      rdc(ADDR_FLOAT, f);
      waitc(2);
      chk({12'h0, pins_o.oe}, {12'h0, ~f[3:2], n[0] ? 2'b11 : ~f[1:0]});
    end
    wr(ADDR_FLOAT, 4'h0);
    wr(ADDR_PORT, 4'hF);
    waitc(2);
    chk({12'h0, pins_o.out}, 16'h3);
    rdc(ADDR_PORT, 4'hF);
    // Divide and duty change only while the tone is off, avoiding glitches.
    for (n = 0; n < 7; n++) begin
      dv = (n == 0) ? 3'h7 : 3'($urandom);
      dt = (n == 0) ? 3'h7 : 3'($urandom);
      wr(ADDR_FREQ, {1'b0, dv});
      wr(ADDR_DUTY, {1'b0, dt});
      wr(ADDR_TONE, 4'h1);
      waitc(150);
      @(negedge ref_clk_i);
      chk(hi_len, exp_high(dv, dt));
      chk(per_len, exp_per(dv));
      chk({15'h0, pins_o.out[INV_PIN]}, {15'h0, ~pins_o.out[TRUE_PIN]});
      wr(ADDR_TONE, 4'h0);
      waitc(3);
      chk({14'h0, pins_o.out[3:2]}, 16'h0);
    end
    chk({15'h0, clash}, 16'h0);
    // With the selects cleared both tone pins show the port data again.
    wr(ADDR_FSEL, 4'h0);
    waitc(2);
    chk({12'h0, pins_o.out}, 16'hF);
    wr(ADDR_FSEL, 4'hC);
    wr(ADDR_FREQ, 4'h0);
    wr(ADDR_DUTY, 4'h5);
    wr(ADDR_TONE, 4'h3);
    waitc(60);
    chk(hi_len, 16'h8);
    waitc(1300);
    chk(hi_len, 16'h1);
    wr(ADDR_TONE, 4'h7);
    waitc(60);
    chk(hi_len, 16'h8);
    wr(ADDR_TONE, 4'h2);
    wr(ADDR_SHOT, 4'h2);
    rdc(ADDR_SHOT, 4'h2);
    rdc(ADDR_TONE, 4'h0);
    n = 0;
    do begin
      rd(ADDR_SHOT, r);
      n++;
    end while (r[1] === 1'b1 && n < 100);
    chk(16'(n >= 28 && n <= 40), 16'h1);
    wr(ADDR_TONE, 4'h1);
    wr(ADDR_SHOT, 4'h2);
    rdc(ADDR_SHOT, 4'h0);
    wr(ADDR_TONE, 4'h0);
    wr(ADDR_SHOT, 4'h3);
    waitc(100);
    rdc(ADDR_SHOT, 4'h3);
    wr(ADDR_SHOT, 4'h5);
    rdc(ADDR_SHOT, 4'h1);
    wr(ADDR_SHOT, 4'h6);
    rdc(ADDR_SHOT, 4'h0);
    results();
  end
endmodule : bsg_top_test
